/* File: mitbu_cpu_model.sv */
// Behavioural model of the CPU sequencer facing the interrupt unit
`timescale 1ns/1ps
module mitbu_cpu_model
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Call side of the unit
  input wire logic callStrobe,
  input wire logic [7:0] callVector,
  // Bench control
  input wire logic holdFull,
  // Towards the unit
  output logic svcSlot,
  output logic stackFull,
  // Observation
  output logic [7:0] lastVec_r,
  output logic [7:0] callCnt_r
);
  // ==========================================================
  // Sequencer
  logic [1:0] slotCnt_r;

  // A slot every fourth cycle, so requests wait a little as on a real core
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      slotCnt_r <= 2'h0;
      svcSlot <= 1'b0;
      stackFull <= 1'b0;
      lastVec_r <= 8'h00;
      callCnt_r <= 8'h00;
    end
    else
    begin
      slotCnt_r <= slotCnt_r + 2'h1;
      svcSlot <= (slotCnt_r == 2'h3);
      stackFull <= holdFull;
      if (callStrobe)
      begin
        lastVec_r <= callVector;
        callCnt_r <= callCnt_r + 8'h01;
      end
    end
  end
endmodule

/* File: mitbu_pkg.sv */
// Types shared by the interrupt and time-base unit
package mitbu_pkg;

  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } mitbu_edge_type;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_EXTA = 3'b001,
    SRC_EXTB = 3'b010,
    SRC_TMR = 3'b011,
    SRC_GRP = 3'b100
  } mitbu_src_type;

  typedef struct packed {
    logic grouped;
    logic nvm;
    logic cmp;
    logic tick1;
    logic tick0;
    logic timer;
    logic extB;
    logic extA;
  } mitbu_flags_type;

  typedef struct packed {
    logic globalIrq;
    logic grouped;
    logic nvm;
    logic cmp;
    logic tick1;
    logic tick0;
    logic timer;
    logic extB;
    logic extA;
  } mitbu_enables_type;

  typedef struct packed {
    logic on;
    logic clkSel;
    logic [1:0] tk1Sel;
    logic [2:0] tk0Sel;
  } mitbu_tbc_type;

endpackage

/* File: mitbu_regs.svh */
// Register offsets, field positions, reset values and counts of the unit
`ifndef MITBU_REGS_SVH
`define MITBU_REGS_SVH

// ==========================================================
// Register byte offsets
`define MIT_OFF_CTRL0 8'h00
`define MIT_OFF_CTRL1 8'h04
`define MIT_OFF_GRPA 8'h08
`define MIT_OFF_GRPB 8'h0C
`define MIT_OFF_EDGE 8'h10
`define MIT_OFF_TBC 8'h14

// ==========================================================
// Field positions
`define MIT_B_TMRF 6
`define MIT_B_EXTBF 5
`define MIT_B_EXTAF 4
`define MIT_B_TMRE 3
`define MIT_B_EXTBE 2
`define MIT_B_EXTAE 1
`define MIT_B_GIE 0
`define MIT_B_GRPF 6
`define MIT_B_GRPE 2
`define MIT_B_TK1F 6
`define MIT_B_TK0F 5
`define MIT_B_TK1E 2
`define MIT_B_TK0E 1
`define MIT_B_NVMF 5
`define MIT_B_CMPF 4
`define MIT_B_NVME 1
`define MIT_B_CMPE 0
`define MIT_F_EDGEB 3:2
`define MIT_F_EDGEA 1:0
`define MIT_B_TKON 7
`define MIT_B_TKCK 6
`define MIT_F_TK1SEL 5:4
`define MIT_F_TK0SEL 2:0

// ==========================================================
// Reset values
`define MIT_RST_FLAGS 8'h00
`define MIT_RST_EN 9'h000
`define MIT_RST_EDGE 2'h0
`define MIT_RST_TBC 8'h37

// ==========================================================
// Vectors and counts
`define MIT_VEC_EXTA 8'h04
`define MIT_VEC_EXTB 8'h08
`define MIT_VEC_TMR 8'h0C
`define MIT_VEC_GRP 8'h18
`define MIT_TK0_BASE 8
`define MIT_TK1_BASE 12
`define MIT_SYS_DIV 4
`define MIT_FILT_LEN 4

`endif

/* File: mitbu_tick_div.sv */
// Shared time-base divider producing the two periodic overflow pulses
`timescale 1ns/1ps
`include "mitbu_regs.svh"
module mitbu_tick_div
  import mitbu_pkg::*;
#(
  parameter int CNT_W = 15,
  parameter int TK0_BASE = `MIT_TK0_BASE,
  parameter int TK1_BASE = `MIT_TK1_BASE
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic tickEn,
  input wire logic run,
  input wire logic [2:0] tk0Sel,
  input wire logic [1:0] tk1Sel,
  // Overflow pulses
  output logic tick0Ovf_r,
  output logic tick1Ovf_r
);

  if (CNT_W < TK0_BASE + 7 || CNT_W < TK1_BASE + 3 || CNT_W > 31)
  begin : badWidth
    $error("mitbu_tick_div: CNT_W cannot serve the period selects");
  end

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] one;
  logic [CNT_W-1:0] mask0;
  logic [CNT_W-1:0] mask1;
  logic wrap0;
  logic wrap1;

  // One counter feeds both bases, so their phases stay related
  assign one = CNT_W'(1);
  assign mask0 = (one << (TK0_BASE + int'(tk0Sel))) - one;
  assign mask1 = (one << (TK1_BASE + int'(tk1Sel))) - one;
  assign wrap0 = run & tickEn & ((count_r & mask0) == mask0);
  assign wrap1 = run & tickEn & ((count_r & mask1) == mask1);

  always_ff @(posedge ref_clk)
  begin
    if (rst || !run)
      count_r <= '0;
    else if (tickEn)
      count_r <= count_r + one;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tick0Ovf_r <= 1'b0;
      tick1Ovf_r <= 1'b0;
    end
    else
    begin
      tick0Ovf_r <= wrap0;
      tick1Ovf_r <= wrap1;
    end
  end

endmodule

/* File: mitbu_top.sv */
// Interrupt request, vectoring and time-base unit with an APB slave
// ==========================================================
// What this block does
// - Two-bit edge select per pin: off, rising, falling, both; pin b upper.
// - Selected edge on an external pin sets its request flag.
// - External vector needs global enable and that pin's enable.
// - External service clears its flag and the global enable.
// - Pin takes external interrupt role only while its enable is set.
// - One filter on/off setting covers both external pins and timer input.
// - Timer overflow sets its flag; call when enabled and stack not full.
// - Timer service clears its flag and the global enable.
// - Time-base overflow sets its flag; service needs global, grouped and own enable.
// - No interrupt is taken while the stack is full.
// - Both time bases divide the tick source clock by a programmed ratio.
// - Grouped flag sets on time-base, comparator or memory-done requests.
// - Grouped vector called when flag, global and grouped enables allow.
// - Grouped service clears grouped flag and the global enable.
// - Individual grouped source flags stay set; software clears them.
// - Either comparator output change sets the comparator flag.
// - Comparator reaches grouped vector only with all three enables.
// - Grouped flag at bit 6, grouped enable bit 2, second control.
// - Tick0 flag bit 5, tick1 flag bit 6, enables bits 1 and 2.
// - Fixed priority: ext a 04H, ext b 08H, timer 0CH, grouped 18H.
// - Global enable clear blocks servicing of every source.
// - Any flag rising raises wake-up, whatever the enables.
`timescale 1ns/1ps
`include "mitbu_regs.svh"
module mitbu_top
  import mitbu_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int FILT_LEN = `MIT_FILT_LEN,
  parameter int TICK_W = 15
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU sequencer
  input wire logic svcSlot,
  input wire logic stackFull,
  output logic callStrobe,
  output logic [7:0] callVector,
  output logic irqPending,
  output logic wakeUp,
  // Pins
  input wire logic extPinA,
  input wire logic extPinB,
  input wire logic timerExtIn,
  input wire logic filterOn,
  output logic extAPinRole,
  output logic extBPinRole,
  output logic timerInFilt,
  // Peripheral events
  input wire logic timerOvf,
  input wire logic [1:0] cmpOut,
  input wire logic nvmDone,
  input wire logic tickSrcEn
);

  if (ADDR_W < 8 || FILT_LEN < 1 || FILT_LEN > 64)
  begin : badParam
    $error("mitbu_top: ADDR_W or FILT_LEN out of range");
  end

  localparam int FCW = $clog2(FILT_LEN) + 1;
  localparam logic [7:0] TbcRst = `MIT_RST_TBC;

  // ==========================================================
  // Registers
  mitbu_flags_type flags_r;
  mitbu_flags_type flagsNxt;
  mitbu_enables_type en_r;
  mitbu_enables_type enNxt;
  mitbu_edge_type edgeA_r;
  mitbu_edge_type edgeB_r;
  mitbu_tbc_type tbc_r;
  logic [31:0] prdata_r;
  logic callStrobe_r;
  logic [7:0] callVector_r;
  logic wakeUp_r;
  logic primed_r;
  logic [2:0] prev_r;
  logic [1:0] cmpPrev_r;
  logic [1:0] sysDiv_r;

  // ==========================================================
  // APB decode
  logic selCtrl0, selCtrl1, selGrpA, selGrpB, selEdge, selTbc;
  logic anyHit, apbSetup, apbWr;
  logic wrCtrl0, wrCtrl1, wrGrpA, wrGrpB, wrEdge, wrTbc;
  logic [7:0] rdByte;

  assign selCtrl0 = paddr == ADDR_W'(`MIT_OFF_CTRL0);
  assign selCtrl1 = paddr == ADDR_W'(`MIT_OFF_CTRL1);
  assign selGrpA = paddr == ADDR_W'(`MIT_OFF_GRPA);
  assign selGrpB = paddr == ADDR_W'(`MIT_OFF_GRPB);
  assign selEdge = paddr == ADDR_W'(`MIT_OFF_EDGE);
  assign selTbc = paddr == ADDR_W'(`MIT_OFF_TBC);
  assign anyHit = selCtrl0 | selCtrl1 | selGrpA | selGrpB | selEdge | selTbc;
  assign apbSetup = psel & ~penable;
  // Registers are one byte wide, so only lane 0 carries a write
  assign apbWr = psel & penable & pwrite & pstrb[0];
  assign wrCtrl0 = apbWr & selCtrl0;
  assign wrCtrl1 = apbWr & selCtrl1;
  assign wrGrpA = apbWr & selGrpA;
  assign wrGrpB = apbWr & selGrpB;
  assign wrEdge = apbWr & selEdge;
  assign wrTbc = apbWr & selTbc;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~anyHit;
  assign prdata = prdata_r;

  always_comb
  begin
    rdByte = 8'h00;
    if (selCtrl0)
    begin
      rdByte[`MIT_B_TMRF] = flags_r.timer;
      rdByte[`MIT_B_EXTBF] = flags_r.extB;
      rdByte[`MIT_B_EXTAF] = flags_r.extA;
      rdByte[`MIT_B_TMRE] = en_r.timer;
      rdByte[`MIT_B_EXTBE] = en_r.extB;
      rdByte[`MIT_B_EXTAE] = en_r.extA;
      rdByte[`MIT_B_GIE] = en_r.globalIrq;
    end
    else if (selCtrl1)
    begin
      rdByte[`MIT_B_GRPF] = flags_r.grouped;
      rdByte[`MIT_B_GRPE] = en_r.grouped;
    end
    else if (selGrpA)
    begin
      rdByte[`MIT_B_TK1F] = flags_r.tick1;
      rdByte[`MIT_B_TK0F] = flags_r.tick0;
      rdByte[`MIT_B_TK1E] = en_r.tick1;
      rdByte[`MIT_B_TK0E] = en_r.tick0;
    end
    else if (selGrpB)
    begin
      rdByte[`MIT_B_NVMF] = flags_r.nvm;
      rdByte[`MIT_B_CMPF] = flags_r.cmp;
      rdByte[`MIT_B_NVME] = en_r.nvm;
      rdByte[`MIT_B_CMPE] = en_r.cmp;
    end
    else if (selEdge)
    begin
      rdByte[`MIT_F_EDGEB] = edgeB_r;
      rdByte[`MIT_F_EDGEA] = edgeA_r;
    end
    else if (selTbc)
    begin
      rdByte[`MIT_B_TKON] = tbc_r.on;
      rdByte[`MIT_B_TKCK] = tbc_r.clkSel;
      rdByte[`MIT_F_TK1SEL] = tbc_r.tk1Sel;
      rdByte[`MIT_F_TK0SEL] = tbc_r.tk0Sel;
    end
  end

  // ==========================================================
  // Input filter, one setting for all three inputs
  logic [2:0] rawIn;
  logic [2:0] filt;
  assign rawIn = {timerExtIn, extPinB, extPinA};

  for (genvar g = 0; g < 3; g++)
  begin : gFilt
    logic [FCW-1:0] stable_r;
    logic bit_r;
    assign filt[g] = bit_r;
    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        stable_r <= '0;
        bit_r <= 1'b0;
      end
      else if (!filterOn || rawIn[g] == bit_r)
      begin
        stable_r <= '0;
        bit_r <= rawIn[g];
      end
      else if (stable_r == FCW'(FILT_LEN - 1))
      begin
        stable_r <= '0;
        bit_r <= rawIn[g];
      end
      else
        stable_r <= stable_r + FCW'(1);
    end
  end

  assign timerInFilt = filt[2];

  // ==========================================================
  // Event detection
  logic [2:0] rise, fall;
  logic [1:0] edgeABits, edgeBBits;
  logic extAHit, extBHit, cmpChange;
  logic tickEn, sysQuarterEn, tick0Ovf, tick1Ovf;

  // Edges are ignored until the history has been loaded once
  assign rise = filt & ~prev_r & {3{primed_r}};
  assign fall = ~filt & prev_r & {3{primed_r}};
  assign edgeABits = edgeA_r;
  assign edgeBBits = edgeB_r;
  assign extAHit = (edgeABits[0] & rise[0]) | (edgeABits[1] & fall[0]);
  assign extBHit = (edgeBBits[0] & rise[1]) | (edgeBBits[1] & fall[1]);
  assign cmpChange = primed_r & (|(cmpOut ^ cmpPrev_r));
  assign sysQuarterEn = sysDiv_r == 2'(`MIT_SYS_DIV - 1);
  assign tickEn = tbc_r.clkSel ? sysQuarterEn : tickSrcEn;

  mitbu_tick_div #(
    .CNT_W(TICK_W),
    .TK0_BASE(`MIT_TK0_BASE),
    .TK1_BASE(`MIT_TK1_BASE)
  ) uTickDiv (
    .ref_clk(ref_clk),
    .rst(rst),
    .tickEn(tickEn),
    .run(tbc_r.on),
    .tk0Sel(tbc_r.tk0Sel),
    .tk1Sel(tbc_r.tk1Sel),
    .tick0Ovf_r(tick0Ovf),
    .tick1Ovf_r(tick1Ovf)
  );

  // ==========================================================
  // Service selection
  logic reqExtA, reqExtB, reqTmr, reqGrp, canTake, callTake;
  mitbu_src_type svcSrc;
  logic [7:0] svcVec;

  assign reqExtA = flags_r.extA & en_r.extA;
  assign reqExtB = flags_r.extB & en_r.extB;
  assign reqTmr = flags_r.timer & en_r.timer;
  assign reqGrp = flags_r.grouped & en_r.grouped;
  assign canTake = svcSlot & en_r.globalIrq & ~stackFull;
  assign svcSrc = !canTake ? SRC_NONE :
                  reqExtA ? SRC_EXTA :
                  reqExtB ? SRC_EXTB :
                  reqTmr ? SRC_TMR :
                  reqGrp ? SRC_GRP : SRC_NONE;
  assign callTake = svcSrc != SRC_NONE;
  assign svcVec = (svcSrc == SRC_EXTA) ? `MIT_VEC_EXTA :
                  (svcSrc == SRC_EXTB) ? `MIT_VEC_EXTB :
                  (svcSrc == SRC_TMR) ? `MIT_VEC_TMR : `MIT_VEC_GRP;
  assign irqPending = en_r.globalIrq & ~stackFull &
                      (reqExtA | reqExtB | reqTmr | reqGrp);

  // ==========================================================
  // Flag and enable update
  mitbu_flags_type hwSet, svcClr, swVal, swMask;
  mitbu_enables_type enVal, enMask;

  // Grouped flag only follows sources whose own enable is set
  assign hwSet = '{
    grouped: (tick0Ovf & en_r.tick0) | (tick1Ovf & en_r.tick1) |
             (cmpChange & en_r.cmp) | (nvmDone & en_r.nvm),
    nvm: nvmDone,
    cmp: cmpChange,
    tick1: tick1Ovf,
    tick0: tick0Ovf,
    timer: timerOvf,
    extB: extBHit,
    extA: extAHit};
  // Source flags of the group are never in the clear set
  assign svcClr = '{
    grouped: svcSrc == SRC_GRP,
    nvm: 1'b0,
    cmp: 1'b0,
    tick1: 1'b0,
    tick0: 1'b0,
    timer: svcSrc == SRC_TMR,
    extB: svcSrc == SRC_EXTB,
    extA: svcSrc == SRC_EXTA};
  assign swVal = '{
    grouped: pwdata[`MIT_B_GRPF],
    nvm: pwdata[`MIT_B_NVMF],
    cmp: pwdata[`MIT_B_CMPF],
    tick1: pwdata[`MIT_B_TK1F],
    tick0: pwdata[`MIT_B_TK0F],
    timer: pwdata[`MIT_B_TMRF],
    extB: pwdata[`MIT_B_EXTBF],
    extA: pwdata[`MIT_B_EXTAF]};
  assign swMask = '{grouped: wrCtrl1, nvm: wrGrpB, cmp: wrGrpB,
                    tick1: wrGrpA, tick0: wrGrpA, timer: wrCtrl0,
                    extB: wrCtrl0, extA: wrCtrl0};
  // A hardware event in the same cycle as a clear still lands
  assign flagsNxt = mitbu_flags_type'((flags_r & ~(swMask | svcClr)) |
                    (swVal & swMask) | hwSet);

  assign enVal = '{
    globalIrq: pwdata[`MIT_B_GIE],
    grouped: pwdata[`MIT_B_GRPE],
    nvm: pwdata[`MIT_B_NVME],
    cmp: pwdata[`MIT_B_CMPE],
    tick1: pwdata[`MIT_B_TK1E],
    tick0: pwdata[`MIT_B_TK0E],
    timer: pwdata[`MIT_B_TMRE],
    extB: pwdata[`MIT_B_EXTBE],
    extA: pwdata[`MIT_B_EXTAE]};
  assign enMask = '{globalIrq: wrCtrl0, grouped: wrCtrl1, nvm: wrGrpB,
                    cmp: wrGrpB, tick1: wrGrpA, tick0: wrGrpA,
                    timer: wrCtrl0, extB: wrCtrl0, extA: wrCtrl0};
  assign enNxt = mitbu_enables_type'((en_r & ~enMask) | (enVal & enMask));

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      flags_r <= mitbu_flags_type'(`MIT_RST_FLAGS);
      en_r <= mitbu_enables_type'(`MIT_RST_EN);
    end
    else
    begin
      flags_r <= flagsNxt;
      en_r <= enNxt;
      if (callTake)
        en_r.globalIrq <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      edgeA_r <= mitbu_edge_type'(`MIT_RST_EDGE);
      edgeB_r <= mitbu_edge_type'(`MIT_RST_EDGE);
      tbc_r <= '{on: TbcRst[`MIT_B_TKON], clkSel: TbcRst[`MIT_B_TKCK],
                 tk1Sel: TbcRst[`MIT_F_TK1SEL],
                 tk0Sel: TbcRst[`MIT_F_TK0SEL]};
    end
    else
    begin
      if (wrEdge)
      begin
        edgeA_r <= mitbu_edge_type'(pwdata[`MIT_F_EDGEA]);
        edgeB_r <= mitbu_edge_type'(pwdata[`MIT_F_EDGEB]);
      end
      if (wrTbc)
        tbc_r <= '{on: pwdata[`MIT_B_TKON], clkSel: pwdata[`MIT_B_TKCK],
                   tk1Sel: pwdata[`MIT_F_TK1SEL],
                   tk0Sel: pwdata[`MIT_F_TK0SEL]};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prdata_r <= 32'h0000_0000;
      callStrobe_r <= 1'b0;
      callVector_r <= 8'h00;
      wakeUp_r <= 1'b0;
      primed_r <= 1'b0;
      prev_r <= 3'h0;
      cmpPrev_r <= 2'h0;
      sysDiv_r <= 2'h0;
    end
    else
    begin
      if (apbSetup)
        prdata_r <= {24'h00_0000, rdByte};
      callStrobe_r <= callTake;
      if (callTake)
        callVector_r <= svcVec;
      wakeUp_r <= |(flagsNxt & ~flags_r);
      primed_r <= 1'b1;
      prev_r <= filt;
      cmpPrev_r <= cmpOut;
      sysDiv_r <= sysDiv_r + 2'h1;
    end
  end

  assign callStrobe = callStrobe_r;
  assign callVector = callVector_r;
  assign wakeUp = wakeUp_r;
  assign extAPinRole = en_r.extA;
  assign extBPinRole = en_r.extB;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  callClearsGie_a: assert property (callStrobe_r |-> !en_r.globalIrq)
    else $error("global enable still set after a call");
  fullBlocks_a: assert property (callStrobe_r |-> $past(!stackFull))
    else $error("call taken while stack full");
  gieGates_a: assert property (callStrobe_r |-> $past(en_r.globalIrq))
    else $error("call taken with global enable clear");
  extAFirst_a: assert property ($past(canTake && reqExtA) |->
    callStrobe_r && callVector_r == `MIT_VEC_EXTA)
    else $error("external a not served first");
  grpVecCause_a: assert property (callStrobe_r &&
    callVector_r == `MIT_VEC_GRP |->
    $past(reqGrp && !reqExtA && !reqExtB && !reqTmr))
    else $error("grouped vector without its cause");
  extAClear_a: assert property (callStrobe_r &&
    callVector_r == `MIT_VEC_EXTA && !$past(extAHit) |-> !flags_r.extA)
    else $error("external a flag survived service");
  tmrClear_a: assert property (callStrobe_r &&
    callVector_r == `MIT_VEC_TMR && !$past(timerOvf) |-> !flags_r.timer)
    else $error("timer flag survived service");
  cmpKept_a: assert property (callStrobe_r &&
    $past(flags_r.cmp) && !$past(wrGrpB) |-> flags_r.cmp)
    else $error("comparator flag cleared by service");
  edgeSets_a: assert property (extAHit |=> flags_r.extA)
    else $error("edge did not set external a flag");
  edgeOff_a: assert property (edgeA_r == EDGE_OFF &&
    !flags_r.extA && !wrCtrl0 |=> !flags_r.extA)
    else $error("disabled edge select set a flag");
  wakeRise_a: assert property (|(flags_r & ~$past(flags_r))
    |-> wakeUp_r)
    else $error("flag rose without wake-up");
  tickGrp_a: assert property (tick0Ovf && en_r.tick0
    |=> flags_r.tick0 && flags_r.grouped)
    else $error("tick0 overflow not recorded");

  extCall_c: cover property (callStrobe_r && callVector_r == `MIT_VEC_EXTB);
  grpCall_c: cover property (callStrobe_r && callVector_r == `MIT_VEC_GRP);
  fullWait_c: cover property (svcSlot && stackFull && reqTmr ##[1:20]
    callStrobe_r);
  wake_c: cover property (wakeUp_r && !en_r.globalIrq);

endmodule

/* File: tb_mitbu_top.sv */
// Self-checking testbench of the interrupt and time-base unit
`timescale 1ns/1ps
`include "mitbu_regs.svh"
module tb_mitbu_top
  import mitbu_pkg::*;
;
  // ==========================================================
  // Signals
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic extPinA = 1'b0, extPinB = 1'b0, timerExtIn = 1'b0;
  logic filterOn = 1'b0, timerOvf = 1'b0, nvmDone = 1'b0, holdFull = 1'b0;
  logic [1:0] cmpOut = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, svcSlot, stackFull, callStrobe, irqPending, wakeUp;
  logic extAPinRole, extBPinRole, timerInFilt, tickSrcEn = 1'b0;
  logic [7:0] callVector, lastVec, callCnt;
  int failures = 0, compares = 0, cyc = 0, wakeCnt = 0, filtCnt = 0;
  localparam logic [7:0] MASKS [6] = '{8'h00, 8'h44, 8'h66, 8'h33,
    8'h0F, 8'hF7};

  mitbu_top i_mitbu_top (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .svcSlot(svcSlot), .stackFull(stackFull), .callStrobe(callStrobe),
    .callVector(callVector), .irqPending(irqPending), .wakeUp(wakeUp),
    .extPinA(extPinA), .extPinB(extPinB), .timerExtIn(timerExtIn),
    .filterOn(filterOn), .extAPinRole(extAPinRole),
    .extBPinRole(extBPinRole), .timerInFilt(timerInFilt),
    .timerOvf(timerOvf), .cmpOut(cmpOut), .nvmDone(nvmDone),
    .tickSrcEn(tickSrcEn));
  mitbu_cpu_model i_mitbu_cpu_model (.ref_clk(ref_clk), .rst(rst),
    .callStrobe(callStrobe), .callVector(callVector), .holdFull(holdFull),
    .svcSlot(svcSlot), .stackFull(stackFull), .lastVec_r(lastVec),
    .callCnt_r(callCnt));

  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (wakeUp === 1'b1) wakeCnt <= wakeCnt + 1;
    if (timerInFilt === 1'b1) filtCnt <= filtCnt + 1;
  end

  // ==========================================================
  // Shared tasks
  task automatic report_and_stop();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    check(r, {24'h0, exp});
  endtask
  task automatic wait_call(input logic [7:0] c0);
    int n;
    n = 0;
    while (callCnt === c0 && n < 200)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic pin(input int p, input logic v);
    if (p == 1) extPinB <= v;
    else extPinA <= v;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 6; i++)
      rd_chk(8'(4 * i), (i == 5) ? `MIT_RST_TBC : 8'h00);
    for (int i = 1; i < 6; i++)
    begin
      wr(8'(4 * i), 8'hFF);
      rd_chk(8'(4 * i), MASKS[i]);
    end
    for (int i = 5; i > 0; i--) wr(8'(4 * i), 8'h00);
    apb(1'b0, 8'h20, 8'h00, r, e);
    check(e, 1);
    check(r, 0);
    $display("test registers done");
  endtask
  task automatic t_edges();
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++)
      begin
        wr(`MIT_OFF_EDGE, 8'(c << (2 * p)));
        pin(p, 1'b1);
        tick(6);
        rd_chk(`MIT_OFF_CTRL0, 8'((c & 1) << (4 + p)));
        wr(`MIT_OFF_CTRL0, 8'h00);
        pin(p, 1'b0);
        tick(6);
        rd_chk(`MIT_OFF_CTRL0, 8'(((c >> 1) & 1) << (4 + p)));
        wr(`MIT_OFF_CTRL0, 8'h00);
      end
    $display("test edges done");
  endtask
  task automatic t_filter();
    int f0;
    filterOn <= 1'b1;
    wr(`MIT_OFF_EDGE, 8'h01);
    f0 = filtCnt;
    extPinA <= 1'b1;
    timerExtIn <= 1'b1;
    tick(2);
    extPinA <= 1'b0;
    timerExtIn <= 1'b0;
    tick(8);
    rd_chk(`MIT_OFF_CTRL0, 8'h00);
    check(filtCnt == f0, 1);
    extPinA <= 1'b1;
    timerExtIn <= 1'b1;
    tick(10);
    rd_chk(`MIT_OFF_CTRL0, 8'h10);
    check(timerInFilt, 1);
    extPinA <= 1'b0;
    timerExtIn <= 1'b0;
    filterOn <= 1'b0;
    wr(`MIT_OFF_EDGE, 8'h00);
    wr(`MIT_OFF_CTRL0, 8'h00);
    $display("test filter done");
  endtask
  task automatic t_service();
    logic [7:0] c0;
    c0 = callCnt;
    wr(`MIT_OFF_CTRL0, 8'h5A);
    tick(20);
    check(callCnt, c0);
    wr(`MIT_OFF_CTRL0, 8'h5B);
    wait_call(c0);
    check(lastVec, `MIT_VEC_EXTA);
    check(extAPinRole, 1);
    rd_chk(`MIT_OFF_CTRL0, 8'h4A);
    c0 = callCnt;
    wr(`MIT_OFF_CTRL0, 8'h25);
    wait_call(c0);
    check(lastVec, `MIT_VEC_EXTB);
    check(extBPinRole, 1);
    holdFull <= 1'b1;
    tick(2);
    c0 = callCnt;
    wr(`MIT_OFF_CTRL0, 8'h4B);
    tick(20);
    check(callCnt, c0);
    check(irqPending, 0);
    holdFull <= 1'b0;
    wait_call(c0);
    check(lastVec, `MIT_VEC_TMR);
    rd_chk(`MIT_OFF_CTRL0, 8'h0A);
    timerOvf <= 1'b1;
    tick(1);
    timerOvf <= 1'b0;
    tick(3);
    rd_chk(`MIT_OFF_CTRL0, 8'h4A);
    wr(`MIT_OFF_CTRL0, 8'h00);
    $display("test service done");
  endtask
  task automatic t_grouped();
    logic [7:0] c0;
    int w0;
    wr(`MIT_OFF_CTRL1, 8'h04);
    wr(`MIT_OFF_GRPB, 8'h01);
    c0 = callCnt;
    wr(`MIT_OFF_CTRL0, 8'h01);
    cmpOut <= 2'b01;
    wait_call(c0);
    check(lastVec, `MIT_VEC_GRP);
    rd_chk(`MIT_OFF_GRPB, 8'h11);
    rd_chk(`MIT_OFF_CTRL1, 8'h04);
    wr(`MIT_OFF_GRPB, 8'h01);
    rd_chk(`MIT_OFF_GRPB, 8'h01);
    w0 = wakeCnt;
    wr(`MIT_OFF_GRPB, 8'h02);
    nvmDone <= 1'b1;
    tick(1);
    nvmDone <= 1'b0;
    tick(3);
    rd_chk(`MIT_OFF_GRPB, 8'h22);
    rd_chk(`MIT_OFF_CTRL1, 8'h44);
    check(wakeCnt > w0, 1);
    wr(`MIT_OFF_GRPB, 8'h00);
    wr(`MIT_OFF_CTRL1, 8'h00);
    $display("test grouped done");
  endtask
  task automatic tick_run(input logic [7:0] time_base_control, input int lo, input int hi);
    logic [31:0] r;
    logic e;
    int s, n;
    wr(`MIT_OFF_GRPA, 8'h02);
    wr(`MIT_OFF_TBC, time_base_control);
    s = cyc;
    n = 0;
    r = 32'h0;
    while (r[5] !== 1'b1 && n < 500)
    begin
      apb(1'b0, `MIT_OFF_GRPA, 8'h00, r, e);
      n++;
    end
    check(r[5], 1);
    check((cyc - s) >= lo && (cyc - s) <= hi, 1);
    wr(`MIT_OFF_TBC, 8'h00);
  endtask
  task automatic t_tick();
    // Period is 2^8 ticks; slack covers polling and divider phase
    tick_run(8'hC0, 1000, 1050);
    tickSrcEn <= 1'b1;
    tick_run(8'h80, 250, 280);
    tickSrcEn <= 1'b0;
    wr(`MIT_OFF_GRPA, 8'h00);
    wr(`MIT_OFF_CTRL1, 8'h00);
    $display("test tick done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_edges();
    t_filter();
    t_service();
    t_grouped();
    t_tick();
    report_and_stop();
  end
  initial
  begin
    #1000000;
    failures++;
    report_and_stop();
  end
endmodule
